//--- design/csfr_core.sv
`timescale 1ns/10ps
// Functional notes
// - Port accesses go to the memory location named by the paired pointer.
// - Pointer aiming at a port location reads zero, writes are dropped.
// - Port 0 always hits bank 0; port 1 hits the selected bank.
// - Direct addressing always hits bank 0 regardless of bank select.
// - Bank field code 000 is bank 0, 100 is bank 4, others reserved.
// - Resets clear bank select, except watchdog reset while idle or asleep.
// - Bank register bits 7..3 read zero; bits 2..0 read/write, cleared.
// - Writing program counter low byte jumps in page, adds one dummy cycle.
// - Table read fetches word at pointers; high byte to result register.
// - Status writes never change time-out or power-down flags.
// - Time-out flag cleared by power-up, watchdog clear, halt; set by time-out.
// - Power-down flag cleared by power-up or watchdog clear, set by halt.
// - Carry set on add carry or no subtract borrow; rotates update it.
// - Half-carry set on low-nibble carry or no nibble borrow.
// - Zero flag follows whether the operation result is zero.
// - Overflow flag is carry into MSB xor carry out of MSB.
// - Status bits 7..6 read zero; time-out and power-down are read-only.
// - Interrupts and calls do not save the status register.
// - Both pointers are ordinary readable, writable storage.
// - No direct register moves; transfers and results go through accumulator.
// - Bank 0: SFRs 00..7F, general storage 80..FF; bank 4 display 00..13.
// - Unused special-function locations read zero.
module csfr_core #(
    parameter int PC_WIDTH  = 13,
    parameter int GP_DEPTH  = 128,
    parameter int DISP_SIZE = 20
) (
    // Clock and resets
    input  wire logic                    mclk_i,
    input  wire logic                    rst_i,
    input  wire logic                    por_i,
    input  wire logic                    wdt_reset_i,
    input  wire logic                    low_power_i,
    // Pipeline data-memory port
    input  wire csfr_pkg::csfr_mem_req_t mem_req_i,
    output logic [7:0]                   mem_rdata_o,
    output logic                         mem_rvalid_o,
    // ALU flag update
    input  wire csfr_pkg::csfr_alu_req_t alu_req_i,
    output logic [7:0]                   acc_o,
    output logic [7:0]                   flags_o,
    // System events
    input  wire logic                    wdt_timeout_i,
    input  wire logic                    wdt_clear_instr_i,
    input  wire logic                    halt_instr_i,
    // Program counter
    input  wire logic                    pc_advance_i,
    output logic [PC_WIDTH-1:0]          pc_o,
    output logic                         dummy_cycle_o,
    // Table read
    input  wire logic                    tbl_read_i,
    output logic [PC_WIDTH-1:0]          tbl_addr_o,
    input  wire logic [15:0]             tbl_word_i,
    output logic [7:0]                   tbl_low_o,
    output logic                         tbl_low_valid_o
);

    // Storage
    logic [7:0] gp_mem [GP_DEPTH];
    logic [7:0] disp_mem [DISP_SIZE];
    logic [7:0] ptr0_q, ptr1_q, acc_q, tbl_lo_q, tbl_hi_q, tbl_res_q;
    logic [2:0] bank_q;
    logic [3:0] arith_q;
    logic       to_q, pd_q;
    logic [PC_WIDTH-1:0] pc_q;
    logic       dummy_q, tbl_pend_q;

    // Resolved access
    logic [7:0] eff_addr;
    logic [2:0] eff_bank;
    logic       port_self;
    logic [7:0] rd_val;
    logic       wr_en;
    logic       sfr_wr;

    // ALU results
    logic [7:0] alu_res;
    logic       alu_c, alu_ac, alu_ov, alu_arith;

    csfr_alu u_alu (
        .op_i    (alu_req_i.op),
        .a_i     (alu_req_i.a),
        .b_i     (alu_req_i.b),
        .c_in_i  (arith_q[csfr_pkg::FLAG_C]),
        .res_o   (alu_res),
        .c_o     (alu_c),
        .ac_o    (alu_ac),
        .ov_o    (alu_ov),
        .arith_o (alu_arith)
    );

    // True when an address names one of the two indirect ports
    function automatic logic is_port(input logic [7:0] a);
        return (a == csfr_pkg::ADDR_PORT0) || (a == csfr_pkg::ADDR_PORT1);
    endfunction

    // Address and bank resolution for direct and indirect access
    always_comb begin
        eff_addr  = mem_req_i.addr;
        eff_bank  = csfr_pkg::BANK_0;
        port_self = 1'b0;
        if (mem_req_i.addr == csfr_pkg::ADDR_PORT0) begin
            eff_addr  = ptr0_q;
            eff_bank  = csfr_pkg::BANK_0;
            port_self = is_port(ptr0_q);
        end else if (mem_req_i.addr == csfr_pkg::ADDR_PORT1) begin
            eff_addr  = ptr1_q;
            eff_bank  = bank_q;
            port_self = (bank_q == csfr_pkg::BANK_0) && is_port(ptr1_q);
        end
        wr_en  = mem_req_i.wr && !port_self;
        sfr_wr = wr_en && (eff_bank == csfr_pkg::BANK_0)
                 && (eff_addr < csfr_pkg::ADDR_GP_FIRST);
    end

    // Read multiplexer; unused and reserved locations give zero
    always_comb begin
        rd_val = 8'h00;
        if (port_self) begin
            rd_val = 8'h00;
        end else if (eff_bank == csfr_pkg::BANK_4) begin
            if (eff_addr <= csfr_pkg::DISP_LAST) begin
                rd_val = disp_mem[eff_addr[4:0]];
            end
        end else if (eff_bank == csfr_pkg::BANK_0) begin
            if (eff_addr >= csfr_pkg::ADDR_GP_FIRST) begin
                rd_val = gp_mem[eff_addr[6:0]];
            end else begin
                unique case (eff_addr)
                    csfr_pkg::ADDR_PTR0:       rd_val = ptr0_q;
                    csfr_pkg::ADDR_PTR1:       rd_val = ptr1_q;
                    csfr_pkg::ADDR_BANK_SEL:   rd_val = {5'h00, bank_q};
                    csfr_pkg::ADDR_ACC:        rd_val = acc_q;
                    csfr_pkg::ADDR_PC_LOW:     rd_val = pc_q[7:0];
                    csfr_pkg::ADDR_TBL_LOW:    rd_val = tbl_lo_q;
                    csfr_pkg::ADDR_TBL_RESULT: rd_val = tbl_res_q;
                    csfr_pkg::ADDR_TBL_HIGH:   rd_val = tbl_hi_q;
                    csfr_pkg::ADDR_FLAGS:      rd_val = {2'b00, to_q, pd_q, arith_q};
                    default:                   rd_val = 8'h00;
                endcase
            end
        end
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mem_rdata_o  <= csfr_pkg::BYTE_RESET;
            mem_rvalid_o <= 1'b0;
        end else begin
            mem_rdata_o  <= rd_val;
            mem_rvalid_o <= mem_req_i.rd;
        end
    end

    // General-purpose and display storage; no reset, contents are volatile
    always_ff @(posedge mclk_i) begin
        if (wr_en && eff_bank == csfr_pkg::BANK_0 && eff_addr >= csfr_pkg::ADDR_GP_FIRST) begin
            gp_mem[eff_addr[6:0]] <= mem_req_i.wdata;
        end
        if (wr_en && eff_bank == csfr_pkg::BANK_4 && eff_addr <= csfr_pkg::DISP_LAST) begin
            disp_mem[eff_addr[4:0]] <= mem_req_i.wdata;
        end
    end

    // Memory pointers as plain storage
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ptr0_q <= csfr_pkg::BYTE_RESET;
            ptr1_q <= csfr_pkg::BYTE_RESET;
        end else if (sfr_wr) begin
            if (eff_addr == csfr_pkg::ADDR_PTR0) ptr0_q <= mem_req_i.wdata;
            if (eff_addr == csfr_pkg::ADDR_PTR1) ptr1_q <= mem_req_i.wdata;
        end
    end

    // Bank select; a watchdog reset in low power keeps the bank
    always_ff @(posedge mclk_i) begin
        if (rst_i && !(wdt_reset_i && low_power_i && !por_i)) begin
            bank_q <= csfr_pkg::BANK_RESET;
        end else if (!rst_i && sfr_wr && eff_addr == csfr_pkg::ADDR_BANK_SEL) begin
            bank_q <= mem_req_i.wdata[2:0];
        end
    end

    // Accumulator: the only path for transfers and ALU results
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            acc_q <= csfr_pkg::BYTE_RESET;
        end else if (alu_req_i.acc_wr) begin
            acc_q <= alu_res;
        end else if (sfr_wr && eff_addr == csfr_pkg::ADDR_ACC) begin
            acc_q <= mem_req_i.wdata;
        end
    end

    // Program counter; low byte write jumps inside the page
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pc_q    <= '0;
            dummy_q <= 1'b0;
        end else if (sfr_wr && eff_addr == csfr_pkg::ADDR_PC_LOW) begin
            pc_q[7:0] <= mem_req_i.wdata;
            dummy_q   <= 1'b1;
        end else begin
            dummy_q <= 1'b0;
            if (pc_advance_i && !dummy_q) begin
                pc_q <= pc_q + PC_WIDTH'(1);
            end
        end
    end

    // Table pointers and result; the fetched word lands two cycles after the request
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tbl_lo_q   <= csfr_pkg::BYTE_RESET;
            tbl_hi_q   <= csfr_pkg::BYTE_RESET;
            tbl_res_q  <= csfr_pkg::BYTE_RESET;
            tbl_pend_q <= 1'b0;
            tbl_low_o  <= csfr_pkg::BYTE_RESET;
            tbl_low_valid_o <= 1'b0;
        end else begin
            tbl_pend_q      <= tbl_read_i;
            tbl_low_valid_o <= tbl_pend_q;
            if (tbl_pend_q) begin
                tbl_res_q <= tbl_word_i[15:8];
                tbl_low_o <= tbl_word_i[7:0];
            end
            if (sfr_wr && eff_addr == csfr_pkg::ADDR_TBL_LOW) tbl_lo_q <= mem_req_i.wdata;
            if (sfr_wr && eff_addr == csfr_pkg::ADDR_TBL_HIGH) tbl_hi_q <= mem_req_i.wdata;
        end
    end

    // Table address from both pointers, held in a register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tbl_addr_o <= '0;
        end else begin
            tbl_addr_o <= PC_WIDTH'({tbl_hi_q, tbl_lo_q});
        end
    end

    // Watchdog and power-down flags; software writes cannot touch them
    always_ff @(posedge mclk_i) begin
        if (rst_i && por_i) begin
            to_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            if (wdt_timeout_i) begin
                to_q <= 1'b1;
            end else if (wdt_clear_instr_i || halt_instr_i) begin
                to_q <= 1'b0;
            end
            if (halt_instr_i) begin
                pd_q <= 1'b1;
            end else if (wdt_clear_instr_i) begin
                pd_q <= 1'b0;
            end
        end
    end

    // Arithmetic flags; left unreset since power-on value is undefined
    always_ff @(posedge mclk_i) begin
        if (alu_req_i.op != csfr_pkg::CSFR_OP_NONE) begin
            arith_q[csfr_pkg::FLAG_Z] <= (alu_res == 8'h00);
            arith_q[csfr_pkg::FLAG_C] <= alu_c;
            if (alu_arith) begin
                arith_q[csfr_pkg::FLAG_AC] <= alu_ac;
                arith_q[csfr_pkg::FLAG_OV] <= alu_ov;
            end
        end else if (!rst_i && sfr_wr && eff_addr == csfr_pkg::ADDR_FLAGS) begin
            arith_q <= mem_req_i.wdata[3:0];
        end
    end

    // Registered views for the pipeline; no status save on calls
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            acc_o   <= csfr_pkg::BYTE_RESET;
            flags_o <= csfr_pkg::BYTE_RESET;
            pc_o    <= '0;
            dummy_cycle_o <= 1'b0;
        end else begin
            acc_o   <= acc_q;
            flags_o <= {2'b00, to_q, pd_q, arith_q};
            pc_o    <= pc_q;
            dummy_cycle_o <= dummy_q;
        end
    end

endmodule

//--- design/csfr_pkg.sv
package csfr_pkg;

    // Special-function addresses and first general-storage address in bank 0
    localparam logic [7:0] ADDR_PORT0      = 8'h00;
    localparam logic [7:0] ADDR_PTR0       = 8'h01;
    localparam logic [7:0] ADDR_PORT1      = 8'h02;
    localparam logic [7:0] ADDR_PTR1       = 8'h03;
    localparam logic [7:0] ADDR_BANK_SEL   = 8'h04;
    localparam logic [7:0] ADDR_ACC        = 8'h05;
    localparam logic [7:0] ADDR_PC_LOW     = 8'h06;
    localparam logic [7:0] ADDR_TBL_LOW    = 8'h07;
    localparam logic [7:0] ADDR_TBL_RESULT = 8'h08;
    localparam logic [7:0] ADDR_TBL_HIGH   = 8'h09;
    localparam logic [7:0] ADDR_FLAGS      = 8'h0a;
    localparam logic [7:0] ADDR_GP_FIRST   = 8'h80;

    // Bank codes and display memory extent
    localparam logic [2:0] BANK_0          = 3'h0;
    localparam logic [2:0] BANK_4          = 3'h4;
    localparam logic [7:0] DISP_LAST       = 8'h13;

    // Flag bit positions
    localparam int FLAG_C  = 0;
    localparam int FLAG_AC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_PD = 4;
    localparam int FLAG_TO = 5;

    // Reset values
    localparam logic [2:0] BANK_RESET      = 3'h0;
    localparam logic [7:0] BYTE_RESET      = 8'h00;

    // ALU operations supplied by the pipeline
    typedef enum logic [2:0] {
        CSFR_OP_NONE,
        CSFR_OP_ADD,
        CSFR_OP_SUB,
        CSFR_OP_LOGIC,
        CSFR_OP_RLC,
        CSFR_OP_RRC
    } csfr_op_t;

    // Data-memory access request from the pipeline
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csfr_mem_req_t;

    // ALU flag update request
    typedef struct packed {
        csfr_op_t   op;
        logic [7:0] a;
        logic [7:0] b;
        logic       acc_wr;
    } csfr_alu_req_t;

endpackage

//--- design/csfr_alu.sv
`timescale 1ns/10ps
// Combinational ALU producing result and arithmetic flags
module csfr_alu (
    // Operands
    input  wire csfr_pkg::csfr_op_t op_i,
    input  wire logic [7:0]         a_i,
    input  wire logic [7:0]         b_i,
    input  wire logic               c_in_i,
    // Results
    output logic [7:0]              res_o,
    output logic                    c_o,
    output logic                    ac_o,
    output logic                    ov_o,
    output logic                    arith_o
);

    logic [4:0] low_sum;
    logic [7:0] low7_sum;
    logic [8:0] full_sum;
    logic [7:0] b_eff;
    logic       cin;

    // Subtraction as add of inverse plus one, so carry means no borrow
    always_comb begin
        b_eff    = (op_i == csfr_pkg::CSFR_OP_SUB) ? ~b_i : b_i;
        cin      = (op_i == csfr_pkg::CSFR_OP_SUB);
        low_sum  = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        low7_sum = {1'b0, a_i[6:0]} + {1'b0, b_eff[6:0]} + {7'h0, cin};
        full_sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h0, cin};
        res_o    = a_i;
        c_o      = c_in_i;
        ac_o     = low_sum[4];
        ov_o     = low7_sum[7] ^ full_sum[8];
        arith_o  = 1'b0;
        unique case (op_i)
            csfr_pkg::CSFR_OP_ADD,
            csfr_pkg::CSFR_OP_SUB: begin
                res_o   = full_sum[7:0];
                c_o     = full_sum[8];
                arith_o = 1'b1;
            end
            csfr_pkg::CSFR_OP_LOGIC: res_o = a_i;
            csfr_pkg::CSFR_OP_RLC: begin
                res_o = {a_i[6:0], c_in_i};
                c_o   = a_i[7];
            end
            csfr_pkg::CSFR_OP_RRC: begin
                res_o = {c_in_i, a_i[7:1]};
                c_o   = a_i[0];
            end
            csfr_pkg::CSFR_OP_NONE: res_o = a_i;
            default: res_o = a_i;
        endcase
    end

endmodule

//--- verification/csfr_prog_mem.sv
`timescale 1ns/10ps
// Program memory seen by the table-read path; answers at once from the address
module csfr_prog_mem #(
    parameter int PC_WIDTH = 13
) (
    // Word address from the table pointers
    input  wire logic [PC_WIDTH-1:0] addr_i,
    // Word returned
    output logic [15:0]              word_o
);
    // Content derived from the address so every word differs
    assign word_o = {~addr_i[7:0], addr_i[7:0] ^ {3'h0, addr_i[PC_WIDTH-1:8]}};
endmodule

//--- verification/csfr_core_props.sv
`timescale 1ns/10ps
// Port-level checks of the core, one clock domain
module csfr_core_props #(
    parameter int PC_WIDTH = 13
) (
    input wire logic                    mclk_i,
    input wire logic                    rst_i,
    input wire csfr_pkg::csfr_mem_req_t mem_req_i,
    input wire logic [7:0]              mem_rdata_o,
    input wire logic                    mem_rvalid_o,
    input wire csfr_pkg::csfr_alu_req_t alu_req_i,
    input wire logic [7:0]              acc_o,
    input wire logic [7:0]              flags_o,
    input wire logic                    wdt_timeout_i,
    input wire logic                    wdt_clear_instr_i,
    input wire logic                    halt_instr_i,
    input wire logic                    pc_advance_i,
    input wire logic [PC_WIDTH-1:0]     pc_o,
    input wire logic                    dummy_cycle_o,
    input wire logic                    tbl_read_i,
    input wire logic [15:0]             tbl_word_i,
    input wire logic [7:0]              tbl_low_o,
    input wire logic                    tbl_low_valid_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Unsigned sum with carry, for the add checks
    logic [8:0] sum_w;
    logic       pcl_wr_w;
    assign sum_w = {1'b0, alu_req_i.a} + {1'b0, alu_req_i.b};
    assign pcl_wr_w = mem_req_i.wr && (mem_req_i.addr == csfr_pkg::ADDR_PC_LOW);

    flags_top_zero_a: assert property (flags_o[7:6] == 2'b00)
        else $error("flag bits 7..6 not zero");
    read_answer_a: assert property (mem_req_i.rd |=> mem_rvalid_o)
        else $error("read got no valid pulse");
    stray_valid_a: assert property (!mem_req_i.rd |=> !mem_rvalid_o)
        else $error("valid pulse without a read");
    bank_upper_zero_a: assert property (mem_req_i.rd &&
        mem_req_i.addr == csfr_pkg::ADDR_BANK_SEL |=> mem_rdata_o[7:3] == 5'h00)
        else $error("bank select upper bits not zero");
    // Flag and pc views lag their state by one register, so effects show two edges on
    timeout_set_a: assert property (wdt_timeout_i |-> ##2 flags_o[csfr_pkg::FLAG_TO])
        else $error("time-out flag not set");
    timeout_clear_a: assert property ((wdt_clear_instr_i || halt_instr_i) &&
        !wdt_timeout_i |-> ##2 !flags_o[csfr_pkg::FLAG_TO])
        else $error("time-out flag not cleared");
    pd_set_a: assert property (halt_instr_i |-> ##2 flags_o[csfr_pkg::FLAG_PD])
        else $error("power-down flag not set");
    pd_clear_a: assert property (wdt_clear_instr_i && !halt_instr_i
        |-> ##2 !flags_o[csfr_pkg::FLAG_PD])
        else $error("power-down flag not cleared");
    sys_flags_hold_a: assert property (!(wdt_timeout_i || wdt_clear_instr_i ||
        halt_instr_i) |-> ##2 $stable(flags_o[5:4]))
        else $error("system flags moved without an event");
    pc_jump_a: assert property (pcl_wr_w && !pc_advance_i |-> ##2
        pc_o[7:0] == $past(mem_req_i.wdata, 2) && $stable(pc_o[PC_WIDTH-1:8]))
        else $error("low byte jump wrong");
    dummy_slot_a: assert property (pcl_wr_w |-> ##2 dummy_cycle_o)
        else $error("no dummy cycle after jump");
    table_low_a: assert property (tbl_read_i |-> ##2 (tbl_low_valid_o &&
        tbl_low_o == $past(tbl_word_i[7:0])))
        else $error("table low byte wrong");
    add_result_a: assert property (alu_req_i.op == csfr_pkg::CSFR_OP_ADD &&
        alu_req_i.acc_wr |-> ##2 acc_o == $past(sum_w[7:0], 2) &&
        flags_o[0] == $past(sum_w[8], 2))
        else $error("add result or carry wrong");
    add_zero_a: assert property (alu_req_i.op == csfr_pkg::CSFR_OP_ADD |-> ##2
        flags_o[csfr_pkg::FLAG_Z] == ($past(sum_w[7:0], 2) == 8'h00))
        else $error("zero flag wrong after add");

    // Main scenarios reached
    cover property (tbl_low_valid_o);
    cover property (dummy_cycle_o);
    cover property (wdt_timeout_i ##2 halt_instr_i);
endmodule

bind csfr_core csfr_core_props #(.PC_WIDTH(PC_WIDTH)) i_props (.mclk_i, .rst_i,
    .mem_req_i, .mem_rdata_o, .mem_rvalid_o, .alu_req_i, .acc_o, .flags_o,
    .wdt_timeout_i, .wdt_clear_instr_i, .halt_instr_i, .pc_advance_i, .pc_o,
    .dummy_cycle_o, .tbl_read_i, .tbl_word_i, .tbl_low_o, .tbl_low_valid_o);

//--- verification/tb_csfr_core.sv
`timescale 1ns/10ps
// Self-checking bench; inputs move 2 ns after each rising edge
module tb_csfr_core;
    localparam int PCW = 13;
    logic                    mclk_i, rst_i, por_i, wdt_reset_i, low_power_i;
    csfr_pkg::csfr_mem_req_t mem_req_i;
    csfr_pkg::csfr_alu_req_t alu_req_i;
    logic [7:0]              mem_rdata_o, acc_o, flags_o, tbl_low_o;
    logic                    mem_rvalid_o, dummy_cycle_o, tbl_low_valid_o;
    logic                    wdt_timeout_i, wdt_clear_instr_i, halt_instr_i;
    logic                    pc_advance_i, tbl_read_i;
    logic [PCW-1:0]          pc_o, tbl_addr_o;
    logic [15:0]             tbl_word_i;
    int                      bad_count, samples_checked, i, seed = 74794;
    logic [31:0]             r;
    logic [7:0]              a, b, d;
    logic [11:0]             e;
    logic                    cf;
    csfr_pkg::csfr_op_t      ops[4];

    csfr_core #(.PC_WIDTH(PCW)) i_dut (.mclk_i, .rst_i, .por_i, .wdt_reset_i,
        .low_power_i, .mem_req_i, .mem_rdata_o, .mem_rvalid_o, .alu_req_i, .acc_o,
        .flags_o, .wdt_timeout_i, .wdt_clear_instr_i, .halt_instr_i, .pc_advance_i,
        .pc_o, .dummy_cycle_o, .tbl_read_i, .tbl_addr_o, .tbl_word_i, .tbl_low_o,
        .tbl_low_valid_o);
    csfr_prog_mem #(.PC_WIDTH(PCW)) i_mem (.addr_i(tbl_addr_o), .word_o(tbl_word_i));

    // 20 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] ex);
        samples_checked++;
        if (got !== ex) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic chk_bit(input logic got, input logic ex);
        chk_byte({7'h00, got}, {7'h00, ex});
    endtask
    task automatic cyc();
        @(posedge mclk_i);
        #2;
    endtask
    // Bus transfers leave one idle cycle so no signal is set twice at once
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        mem_req_i = {1'b0, 1'b1, ad, dt};
        cyc();
        mem_req_i = '0;
        cyc();
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [7:0] ex);
        mem_req_i = {1'b1, 1'b0, ad, 8'h00};
        cyc();
        chk_bit(mem_rvalid_o, 1'b1);
        chk_byte(mem_rdata_o, ex);
        mem_req_i = '0;
        cyc();
    endtask
    task automatic ev(input logic [2:0] evs);
        {wdt_timeout_i, wdt_clear_instr_i, halt_instr_i} = evs;
        cyc();
        {wdt_timeout_i, wdt_clear_instr_i, halt_instr_i} = 3'h0;
        cyc();
    endtask
    task automatic do_rst(input logic p, input logic w, input logic l, input int n);
        {rst_i, por_i, wdt_reset_i, low_power_i} = {1'b1, p, w, l};
        repeat (n) cyc();
        {rst_i, por_i, wdt_reset_i, low_power_i} = 4'h0;
    endtask
    // Expected {result, ov, z, ac, c}; subtraction is a + ~b + 1
    function automatic logic [11:0] alu_exp(input csfr_pkg::csfr_op_t op,
                                            input logic [7:0] x, input logic [7:0] y,
                                            input logic ci);
        logic [7:0] yy;
        logic [8:0] s;
        logic [4:0] h;
        logic       k;
        if (op == csfr_pkg::CSFR_OP_RLC) return {x[6:0], ci, 3'h0, x[7]};
        if (op == csfr_pkg::CSFR_OP_RRC) return {ci, x[7:1], 3'h0, x[0]};
        k = (op == csfr_pkg::CSFR_OP_SUB);
        yy = k ? ~y : y;
        s = {1'b0, x} + {1'b0, yy} + {8'h00, k};
        h = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, k};
        return {s[7:0], (x[7] == yy[7]) && (s[7] != x[7]), s[7:0] == 8'h00, h[4], s[8]};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        repeat (5000) @(posedge mclk_i);
        bad_count++;
        close_out();
    end

    initial begin
        {mem_req_i, alu_req_i, pc_advance_i, tbl_read_i} = '0;
        {wdt_timeout_i, wdt_clear_instr_i, halt_instr_i} = 3'h0;
        {bad_count, samples_checked} = '0;
        ops = '{csfr_pkg::CSFR_OP_ADD, csfr_pkg::CSFR_OP_SUB,
                csfr_pkg::CSFR_OP_RLC, csfr_pkg::CSFR_OP_RRC};
        do_rst(1'b1, 1'b0, 1'b0, 10);
        chk_byte({6'h00, flags_o[5:4]}, 8'h00);
        rchk(csfr_pkg::ADDR_BANK_SEL, 8'h00);
        // Pointer pairs against general storage, random places
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            a = 8'h80 | r[7:0];
            wr(csfr_pkg::ADDR_PTR0, a);
            wr(csfr_pkg::ADDR_PORT0, r[15:8]);
            rchk(a, r[15:8]);
            rchk(csfr_pkg::ADDR_PTR0, a);
            wr(csfr_pkg::ADDR_PTR1, a);
            rchk(csfr_pkg::ADDR_PORT1, r[15:8]);
        end
        // Pointer aimed at a port location itself
        for (i = 0; i < 2; i++) begin
            a = i[0] ? csfr_pkg::ADDR_PORT1 : csfr_pkg::ADDR_PORT0;
            wr(csfr_pkg::ADDR_PTR0, a);
            wr(csfr_pkg::ADDR_PORT0, 8'h5a);
            rchk(csfr_pkg::ADDR_PORT0, 8'h00);
            rchk(csfr_pkg::ADDR_PTR0, a);
        end
        rchk(8'h0b, 8'h00);
        rchk(8'h7f, 8'h00);
        // Bank select: reserved code, bank 4 display, direct stays in bank 0
        wr(csfr_pkg::ADDR_BANK_SEL, 8'hff);
        rchk(csfr_pkg::ADDR_BANK_SEL, 8'h07);
        wr(csfr_pkg::ADDR_BANK_SEL, {5'h00, csfr_pkg::BANK_4});
        wr(csfr_pkg::ADDR_PTR1, csfr_pkg::DISP_LAST);
        wr(csfr_pkg::ADDR_PORT1, 8'hc3);
        wr(csfr_pkg::ADDR_PTR0, 8'h90);
        wr(csfr_pkg::ADDR_PORT0, 8'h3c);
        rchk(8'h90, 8'h3c);
        wr(csfr_pkg::ADDR_PTR1, 8'h90);
        rchk(csfr_pkg::ADDR_PORT1, 8'h00);
        wr(csfr_pkg::ADDR_BANK_SEL, 8'h00);
        rchk(csfr_pkg::ADDR_PORT1, 8'h3c);
        wr(csfr_pkg::ADDR_BANK_SEL, {5'h00, csfr_pkg::BANK_4});
        wr(csfr_pkg::ADDR_PTR1, csfr_pkg::DISP_LAST);
        rchk(csfr_pkg::ADDR_PORT1, 8'hc3);
        // Status writes and system events
        ev(3'b100);
        wr(csfr_pkg::ADDR_FLAGS, 8'hff);
        rchk(csfr_pkg::ADDR_FLAGS, 8'h2f);
        wr(csfr_pkg::ADDR_FLAGS, 8'h00);
        rchk(csfr_pkg::ADDR_FLAGS, 8'h20);
        ev(3'b001);
        rchk(csfr_pkg::ADDR_FLAGS, 8'h10);
        do_rst(1'b0, 1'b1, 1'b1, 2);
        rchk(csfr_pkg::ADDR_BANK_SEL, 8'h04);
        chk_bit(flags_o[csfr_pkg::FLAG_PD], 1'b1);
        ev(3'b010);
        chk_byte({6'h00, flags_o[5:4]}, 8'h00);
        ev(3'b110);
        chk_bit(flags_o[csfr_pkg::FLAG_TO], 1'b1);
        do_rst(1'b0, 1'b1, 1'b0, 2);
        rchk(csfr_pkg::ADDR_BANK_SEL, 8'h00);
        do_rst(1'b1, 1'b0, 1'b0, 2);
        rchk(csfr_pkg::ADDR_FLAGS, 8'h00);
        // Arithmetic through the accumulator, corners first
        cf = 1'b0;
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            {a, b} = (i == 0) ? 16'h7f01 : (i == 1) ? 16'h0000 : (i == 4) ? 16'h8080 : r[15:0];
            e = alu_exp(ops[i % 4], a, b, cf);
            alu_req_i = {ops[i % 4], a, b, 1'b1};
            cyc();
            alu_req_i = '0;
            cyc();
            chk_byte(acc_o, e[11:4]);
            if (i % 4 < 2)
                chk_byte({4'h0, flags_o[3:0]}, {4'h0, e[3:0]});
            else
                chk_bit(flags_o[csfr_pkg::FLAG_C], e[0]);
            cf = e[0];
        end
        rchk(csfr_pkg::ADDR_ACC, e[11:4]);
        // Table reads at random pointers
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(csfr_pkg::ADDR_TBL_LOW, r[7:0]);
            wr(csfr_pkg::ADDR_TBL_HIGH, {3'h0, r[12:8]});
            tbl_read_i = 1'b1;
            cyc();
            tbl_read_i = 1'b0;
            cyc();
            chk_bit(tbl_low_valid_o, 1'b1);
            chk_byte(tbl_low_o, r[7:0] ^ {3'h0, r[12:8]});
            rchk(csfr_pkg::ADDR_TBL_RESULT, ~r[7:0]);
        end
        // Jump inside the current page after 300 steps
        pc_advance_i = 1'b1;
        repeat (300) cyc();
        pc_advance_i = 1'b0;
        wr(csfr_pkg::ADDR_PC_LOW, 8'hf0);
        chk_bit(dummy_cycle_o, 1'b1);
        chk_byte(pc_o[7:0], 8'hf0);
        chk_byte({3'h0, pc_o[12:8]}, 8'h01);
        // Jump while advancing: the dummy slot must hold the pc one cycle
        pc_advance_i = 1'b1;
        wr(csfr_pkg::ADDR_PC_LOW, 8'h20);
        cyc();
        pc_advance_i = 1'b0;
        chk_byte(pc_o[7:0], 8'h20);
        close_out();
    end
endmodule
